// ===== logic/usart_master_spi_control.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Summary of operation
// [R01] receive-complete flag is high while unread received data waits
// [R02] disabling the receiver flushes the receive buffer, clearing receive-complete
// [R03] transmit-complete sets when a frame ends and the transmit buffer is empty
// [R04] transmit-complete clears on interrupt service or a one written to it
// [R05] buffer-empty flag is high whenever the transmit buffer can take data
// [R06] buffer-empty flag reads set right after reset
// [R07] software writes zeros to the reserved bits
// [R08] receive interrupt needs its enable, global enable and the flag
// [R09] transmit-complete interrupt needs its enable, global enable and the flag
// [R10] buffer-empty interrupt needs its enable, global enable and the flag
// [R11] receiver enable claims the serial input pin for receive data
// [R12] receive-only setting moves no data; transmitter makes the clock
// [R13] transmitter enable claims the serial output pin for transmit data
// [R14] transmitter disable waits until shift register and buffer are empty
// [R15] mode field selects mode; both bits one means master spi
// [R16] order, phase and polarity are taken in the mode-selecting write
// [R17] order bit one shifts lsb first, zero msb first
// [R18] phase bit picks leading or trailing clock edge for sampling
// [R19] polarity bit sets the idle level of the transfer clock
// [R20] a data register write starts a transfer that sends and receives
// [R21] frame, overrun and parity error bits read zero
// [R22] on receive overflow the newest byte is dropped
// [R23] eight bits per transfer, one input bit and clock pulse per bit
module usart_master_spi_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        global_irq_en,
  input  wire logic        txc_irq_ack,
  input  wire logic        serial_input_pin,
  output logic             serial_output_pin,
  output logic             serial_output_oe,
  output logic             serial_input_owned,
  output logic             transfer_clock_pin,
  output logic             irq_receive_complete,
  output logic             irq_transmit_complete,
  output logic             irq_tx_buffer_empty
);
  // registers
  logic [7:0]              ctrl_b_r;
  logic [7:0]              ctrl_c_r;
  logic [spim_pkg::BAUD_W-1:0] baud_r;
  logic [spim_pkg::BAUD_W-1:0] div_cnt_r;
  logic                    txc_r;
  logic [7:0]              tx_buf_r;
  logic                    tx_full_r;
  logic [7:0]              tx_sh_r;
  logic [7:0]              rx_sh_r;
  logic [7:0]              rx_mem_r [2];
  logic [1:0]              rx_cnt_r;
  logic [4:0]              half_r;
  spim_pkg::eng_state_t    state_r;
  logic                    sck_r;
  logic                    mosi_r;
  logic                    owned_r;
  logic                    rx_owned_r;
  logic                    in_meta_r;
  logic                    in_sync_r;
  logic [31:0]             prdata_r;
  logic                    pready_r;
  logic                    pslverr_r;
  logic                    pop_ok_r;
  logic                    irq_rx_r;
  logic                    irq_tx_r;
  logic                    irq_ud_r;

  // shift-out helpers honour the bit order
  function automatic logic first_bit(input logic [7:0] d, input logic lsb);
    first_bit = lsb ? d[0] : d[7];
  endfunction : first_bit

  function automatic logic [7:0] shift_out(input logic [7:0] d, input logic lsb);
    shift_out = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction : shift_out

  // bus decode
  wire acc       = psel & penable & pready_r;
  wire wr        = acc & pwrite;
  wire sel_stat  = paddr == spim_pkg::ADDR_STATUS;
  wire sel_b     = paddr == spim_pkg::ADDR_CTRL_B;
  wire sel_c     = paddr == spim_pkg::ADDR_CTRL_C;
  wire sel_data  = paddr == spim_pkg::ADDR_DATA;
  wire sel_baud  = paddr == spim_pkg::ADDR_BAUD;
  wire mapped    = sel_stat | sel_b | sel_c | sel_data | sel_baud;
  wire rxen      = ctrl_b_r[spim_pkg::RXEN_BIT];
  wire txen      = ctrl_b_r[spim_pkg::TXEN_BIT];
  wire lsb_first = ctrl_c_r[spim_pkg::ORDER_BIT];
  wire cpha      = ctrl_c_r[spim_pkg::PHASE_BIT];
  wire cpol      = ctrl_c_r[spim_pkg::POL_BIT];
  wire spi_mode  = ctrl_c_r[spim_pkg::MODE_HI:spim_pkg::MODE_LO] == spim_pkg::MODE_SPI; // see [R15]
  wire rxc       = rx_cnt_r != 2'h0;                                // see [R01]
  wire udre      = ~tx_full_r;                                      // see [R05] see [R06]
  wire busy      = state_r == spim_pkg::ST_SHIFT;
  wire tick      = busy & (div_cnt_r == baud_r);
  wire leading   = ~half_r[0];
  wire last_half = half_r == spim_pkg::LAST_HALF;
  wire sample    = tick & (leading ^ cpha);                         // see [R18]
  wire drive     = tick & (leading ~^ cpha) & ~(last_half & ~cpha);
  wire finish    = tick & last_half;
  wire start     = spi_mode & tx_full_r & ~busy & owned_r;          // see [R20]
  wire data_wr   = wr & sel_data & txen & ~tx_full_r;
  wire data_rd   = acc & ~pwrite & sel_data & pop_ok_r;
  wire [7:0] rx_next = lsb_first ? {in_sync_r, rx_sh_r[7:1]} : {rx_sh_r[6:0], in_sync_r}; // see [R17]
  wire push      = finish & rxen & (rx_cnt_r != spim_pkg::RX_DEPTH); // see [R22]
  wire txc_set   = finish & ~tx_full_r;                             // see [R03]
  wire txc_clr   = txc_irq_ack | (wr & sel_stat & pwdata[spim_pkg::TXC_BIT]); // see [R04]
  wire [7:0] stat_rd = {rxc, txc_r, udre, 5'h00};                   // see [R21]
  wire [7:0] rd_byte = sel_stat ? stat_rd :
                       sel_b    ? ctrl_b_r :
                       sel_c    ? ctrl_c_r :
                       sel_data ? rx_mem_r[0] : 8'h00;
  wire [31:0] rd_word = sel_baud ? {20'h00000, baud_r} : {24'h000000, rd_byte};

  // apb answer one wait state after the access phase begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
      pop_ok_r  <= 1'b0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      pop_ok_r  <= rxc;
      if (psel & penable & ~pready_r) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  // control registers; one write takes mode and format together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_r <= spim_pkg::CTRL_B_RESET;
      ctrl_c_r <= spim_pkg::CTRL_C_RESET;
      baud_r   <= spim_pkg::BAUD_RESET;
    end else begin
      if (wr & sel_b) begin
        ctrl_b_r <= pwdata[7:0] & spim_pkg::CTRL_B_MASK;
      end
      if (wr & sel_c) begin
        ctrl_c_r <= pwdata[7:0] & spim_pkg::CTRL_C_MASK; // see [R16]
      end
      if (wr & sel_baud) begin
        baud_r <= pwdata[spim_pkg::BAUD_W-1:0];
      end
    end
  end

  // transmit-complete flag, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_r <= 1'b0;
    end else begin
      txc_r <= txc_set | (txc_r & ~txc_clr); // see [R03] see [R04]
    end
  end

  // transmit buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_full_r <= 1'b0;
      tx_buf_r  <= 8'h00;
    end else begin
      if (data_wr) begin
        tx_buf_r  <= pwdata[7:0];
        tx_full_r <= 1'b1;
      end else if (start) begin
        tx_full_r <= 1'b0;
      end
    end
  end

  // pin ownership; output held until all data left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owned_r    <= 1'b0;
      rx_owned_r <= 1'b0;
    end else begin
      owned_r    <= txen | busy | tx_full_r; // see [R13] see [R14]
      rx_owned_r <= rxen;                    // see [R11]
    end
  end

  // input pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta_r <= 1'b0;
      in_sync_r <= 1'b0;
    end else begin
      in_meta_r <= serial_input_pin;
      in_sync_r <= in_meta_r;
    end
  end

  // half-period divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= (~busy | tick) ? '0 : div_cnt_r + 1'b1;
    end
  end

  // shift engine: sixteen clock edges per word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= spim_pkg::ST_IDLE;
      half_r  <= 5'h00;
      sck_r   <= 1'b0;
      mosi_r  <= 1'b1;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
    end else begin
      case (state_r)
        spim_pkg::ST_IDLE: begin
          sck_r  <= cpol; // see [R19]
          half_r <= 5'h00;
          if (start) begin
            state_r <= spim_pkg::ST_SHIFT;
            if (!cpha) begin
              mosi_r  <= first_bit(tx_buf_r, lsb_first);
              tx_sh_r <= shift_out(tx_buf_r, lsb_first);
            end else begin
              tx_sh_r <= tx_buf_r;
            end
          end
        end
        spim_pkg::ST_SHIFT: begin
          if (tick) begin
            sck_r  <= ~sck_r; // see [R23]
            half_r <= half_r + 5'h01;
          end
          if (drive) begin
            mosi_r  <= first_bit(tx_sh_r, lsb_first); // see [R17]
            tx_sh_r <= shift_out(tx_sh_r, lsb_first);
          end
          if (sample) begin
            rx_sh_r <= rx_next; // see [R23]
          end
          if (finish) begin
            state_r <= spim_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= spim_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // received word: with phase set the last edge samples into the buffer directly
  wire [7:0] rx_word = cpha ? rx_next : rx_sh_r;

  // two-level receive buffer, flushed when receiver is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_r    <= 2'h0;
      rx_mem_r[0] <= 8'h00;
      rx_mem_r[1] <= 8'h00;
    end else if (!rxen) begin
      rx_cnt_r <= 2'h0; // see [R02]
    end else begin
      case ({push, data_rd})
        2'b10: begin
          rx_mem_r[rx_cnt_r[0]] <= rx_word;
          rx_cnt_r <= rx_cnt_r + 2'h1;
        end
        2'b01: begin
          rx_mem_r[0] <= rx_mem_r[1];
          rx_cnt_r <= rx_cnt_r - 2'h1;
        end
        2'b11: begin
          rx_mem_r[0] <= (rx_cnt_r == 2'h1) ? rx_word : rx_mem_r[1];
          rx_mem_r[1] <= rx_word;
        end
        default: begin
          rx_cnt_r <= rx_cnt_r;
        end
      endcase
    end
  end

  // interrupt lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_rx_r <= 1'b0;
      irq_tx_r <= 1'b0;
      irq_ud_r <= 1'b0;
    end else begin
      irq_rx_r <= ctrl_b_r[spim_pkg::RXCIE_BIT] & global_irq_en & rxc;   // see [R08]
      irq_tx_r <= ctrl_b_r[spim_pkg::TXCIE_BIT] & global_irq_en & txc_r; // see [R09]
      irq_ud_r <= ctrl_b_r[spim_pkg::TX_BUFFER_EMPTY_IRQ_EN_BIT] & global_irq_en & udre;  // see [R10]
    end
  end

  assign prdata                = prdata_r;
  assign pready                = pready_r;
  assign pslverr               = pslverr_r;
  assign serial_output_pin     = mosi_r;
  assign serial_output_oe      = owned_r;
  assign serial_input_owned    = rx_owned_r;
  assign transfer_clock_pin    = sck_r;
  assign irq_receive_complete  = irq_rx_r;
  assign irq_transmit_complete = irq_tx_r;
  assign irq_tx_buffer_empty   = irq_ud_r;

  // checks
  property p_rxc_irq;
    @(posedge pclk) disable iff (!presetn)
    irq_rx_r |-> $past(ctrl_b_r[spim_pkg::RXCIE_BIT] & global_irq_en & rxc);
  endproperty
  a_rxc_irq: assert property (p_rxc_irq) else $error("rx irq without cause"); // see [R08]
  property p_txc_irq;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_b_r[spim_pkg::TXCIE_BIT] & global_irq_en & txc_r) |=> irq_tx_r;
  endproperty
  a_txc_irq: assert property (p_txc_irq) else $error("tx irq missing"); // see [R09]
  property p_ud_irq;
    @(posedge pclk) disable iff (!presetn)
    irq_ud_r |-> $past(udre);
  endproperty
  a_ud_irq: assert property (p_ud_irq) else $error("empty irq while full"); // see [R10]
  property p_flush;
    @(posedge pclk) disable iff (!presetn)
    !rxen |=> !rxc;
  endproperty
  a_flush: assert property (p_flush) else $error("buffer not flushed"); // see [R02]
  property p_txc_set;
    @(posedge pclk) disable iff (!presetn)
    (finish & ~tx_full_r) |=> txc_r;
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("tx complete not set"); // see [R03]
  property p_txc_clr;
    @(posedge pclk) disable iff (!presetn)
    (txc_r & txc_irq_ack & ~finish) |=> !txc_r;
  endproperty
  a_txc_clr: assert property (p_txc_clr) else $error("tx complete not cleared"); // see [R04]
  property p_hold_pin;
    @(posedge pclk) disable iff (!presetn)
    (busy & ~txen) |=> serial_output_oe;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("output released early"); // see [R14]
  property p_idle_clk;
    @(posedge pclk) disable iff (!presetn)
    (!busy && $past(!busy) && $stable(cpol)) |-> (sck_r == cpol);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level wrong"); // see [R19]
  property p_word_len;
    @(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> (half_r == spim_pkg::LAST_HALF + 5'h01);
  endproperty
  a_word_len: assert property (p_word_len) else $error("word length wrong"); // see [R23]
  property p_overflow;
    @(posedge pclk) disable iff (!presetn)
    (rx_cnt_r == spim_pkg::RX_DEPTH && finish && !data_rd) |=> $stable(rx_mem_r[0]) && $stable(rx_mem_r[1]);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow kept newest"); // see [R22]
endmodule : usart_master_spi_control

// ===== shared/spim_pkg.sv
package spim_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_DATA   = 8'h0c;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;
  // status bits
  localparam int RXC_BIT  = 7;
  localparam int TXC_BIT  = 6;
  localparam int UDRE_BIT = 5;
  // control b bits
  localparam int RXCIE_BIT = 7;
  localparam int TXCIE_BIT = 6;
  localparam int TX_BUFFER_EMPTY_IRQ_EN_BIT = 5;
  localparam int RXEN_BIT  = 4;
  localparam int TXEN_BIT  = 3;
  // control c bits
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int ORDER_BIT = 2;
  localparam int PHASE_BIT = 1;
  localparam int POL_BIT   = 0;
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_RSVD  = 2'h2;
  localparam logic [1:0] MODE_SPI   = 2'h3;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_C_RESET = 8'h06;
  localparam logic [7:0] CTRL_B_MASK  = 8'hf8;
  localparam logic [7:0] CTRL_C_MASK  = 8'hc7;
  localparam logic [11:0] BAUD_RESET  = 12'h000;
  localparam int BAUD_W = 12;
  // word and buffer geometry
  localparam int WORD_W   = 8;
  localparam logic [4:0] LAST_HALF = 5'h0f;
  localparam logic [1:0] RX_DEPTH = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01
  } eng_state_t;
endpackage : spim_pkg

// ===== tb/spi_slave_model.sv
`timescale 1ns/100ps
// behavioural slave: sends tx_base plus frame number, captures master data
module spi_slave_model (
  input  wire logic       pclk,
  input  wire logic       armed,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb_first,
  input  wire logic [7:0] tx_base,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  output logic      [7:0] rx_byte,
  output logic      [7:0] edge_cnt,
  output logic      [7:0] frame_cnt
);
  logic [7:0] rx_sh;
  logic [7:0] tx_now;
  logic [3:0] shifts;
  logic [2:0] bit_i;
  logic       idle_pat = 1'b0;
  // filler that changes every cycle while the slave is not armed
  always @(posedge pclk) idle_pat <= ~idle_pat;
  // restart counts when the bench arms the slave
  always @(posedge armed) begin
    edge_cnt = 8'h00;
    frame_cnt = 8'h00;
    shifts = 4'h0;
  end
  // sample on one edge kind, shift on the other
  always @(sck) begin
    if (armed) begin
      edge_cnt = edge_cnt + 8'h01;
      if ((sck != cpol) != cpha) begin
        rx_sh = lsb_first ? {mosi, rx_sh[7:1]} : {rx_sh[6:0], mosi};
      end else begin
        shifts = shifts + 4'h1;
      end
      if (edge_cnt[3:0] == 4'h0) begin
        rx_byte = rx_sh;
        frame_cnt = frame_cnt + 8'h01;
        shifts = 4'h0;
      end
    end
  end
  // present the current bit of the outgoing word
  always_comb begin
    tx_now = tx_base + frame_cnt;
    bit_i = (cpha && shifts != 4'h0) ? 3'(shifts - 4'h1) : shifts[2:0];
    if (!lsb_first) bit_i = 3'h7 - bit_i;
    miso = armed ? tx_now[bit_i] : idle_pat;
  end
endmodule : spi_slave_model

// ===== tb/usart_master_spi_control_tb.sv
`timescale 1ns/100ps
module usart_master_spi_control_tb;
  localparam logic [7:0] A_ST = spim_pkg::ADDR_STATUS;
  localparam logic [7:0] A_B  = spim_pkg::ADDR_CTRL_B;
  localparam logic [7:0] A_C  = spim_pkg::ADDR_CTRL_C;
  localparam logic [7:0] A_D  = spim_pkg::ADDR_DATA;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        global_irq_en = 1'b0;
  logic        txc_irq_ack = 1'b0;
  logic        miso;
  logic        mosi;
  logic        mosi_oe;
  logic        rx_owned;
  logic        sck;
  wire  [2:0]  irq;
  logic        armed = 1'b0;
  logic        cpol = 1'b0;
  logic        cpha = 1'b0;
  logic        lsb = 1'b0;
  logic [7:0]  base = 8'h00;
  logic [7:0]  rx_byte;
  logic [7:0]  edge_cnt;
  logic [31:0] rdata;
  logic        rerr;
  logic [7:0]  tx;
  logic [2:0]  ie;
  logic [7:0]  exp_q[$];
  int          k;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          seed = 5760;

  always #10 pclk = ~pclk;

  usart_master_spi_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_en(global_irq_en), .txc_irq_ack(txc_irq_ack), .serial_input_pin(miso),
    .serial_output_pin(mosi), .serial_output_oe(mosi_oe), .serial_input_owned(rx_owned),
    .transfer_clock_pin(sck), .irq_receive_complete(irq[2]), .irq_transmit_complete(irq[1]),
    .irq_tx_buffer_empty(irq[0]));

  spi_slave_model slave (.pclk(pclk), .armed(armed), .cpol(cpol), .cpha(cpha), .lsb_first(lsb),
    .tx_base(base), .sck(sck), .mosi(mosi), .miso(miso), .rx_byte(rx_byte), .edge_cnt(edge_cnt),
    .frame_cnt());

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("apb wait", 32'd2, n);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // poll one status bit with a bounded number of reads
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(A_ST);
      n++;
    end while (rdata[b] !== v && n < 300);
    chk("status poll", {31'h0, v}, {31'h0, rdata[b]});
  endtask : wait_st

  task automatic arm();
    armed <= 1'b0;
    @(posedge pclk);
    armed <= 1'b1;
    base <= 8'($random(seed));
    k = 0;
    @(posedge pclk);
  endtask : arm

  // queue a byte once the buffer is free; keep says whether its reply will be read back
  task automatic push_tx(input logic keep);
    tx = 8'($random(seed));
    wait_st(5, 1'b1);
    wr(A_D, {24'h0, tx});
    if (keep) exp_q.push_back(8'(base + k));
    k++;
  endtask : push_tx

  task automatic rd_data();
    rd(A_D);
    chk("rx byte", {24'h0, exp_q.pop_front()}, rdata);
  endtask : rd_data

  // watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_ST);
    chk("status after reset", 32'h20, rdata);
    chk("slave error", 32'h0, {31'h0, rerr});
    rd(A_C);
    chk("mode after reset", 32'h06, rdata);
    rd(8'h14);
    chk("unmapped", 32'h1, {31'h0, rerr});
    for (int cfg = 0; cfg < 8; cfg++) begin
      lsb <= cfg[2];
      cpha <= cfg[1];
      cpol <= cfg[0];
      ie = 3'($random(seed));
      global_irq_en <= 1'($random(seed));
      wr(A_C, 32'hc0 | cfg);
      wr(A_B, {24'h0, ie, 5'h18});
      wr(spim_pkg::ADDR_BAUD, 32'h3);
      arm();
      rd(A_C);
      chk("mode", 32'hc0 | cfg, rdata);
      chk("idle clock", {31'h0, cpol}, {31'h0, sck});
      chk("pins owned", 32'h3, {30'h0, mosi_oe, rx_owned});
      push_tx(1'b1);
      wait_st(7, 1'b1);
      chk("mosi byte", {24'h0, tx}, {24'h0, rx_byte});
      chk("edges", 32'd16, {24'h0, edge_cnt});
      repeat (2) @(posedge pclk);
      chk("irq", {29'h0, ie & {3{global_irq_en}}}, {29'h0, irq});
      txc_irq_ack <= 1'b1;
      @(posedge pclk);
      txc_irq_ack <= 1'b0;
      rd(A_ST);
      chk("status after ack", 32'ha0, rdata);
      rd_data();
      rd(A_ST);
      chk("status drained", 32'h20, rdata);
    end
    // three back-to-back frames, transmitter dropped while two are pending
    arm();
    push_tx(1'b1);
    push_tx(1'b1);
    push_tx(1'b0);
    wr(A_B, 32'h10);
    chk("output held", 32'h1, {31'h0, mosi_oe});
    wait_st(6, 1'b1);
    repeat (3) @(posedge pclk);
    chk("output released", 32'h0, {31'h0, mosi_oe});
    chk("edges", 32'd48, {24'h0, edge_cnt});
    chk("last mosi", {24'h0, tx}, {24'h0, rx_byte});
    rd_data();
    rd_data();
    rd(A_ST);
    chk("status", 32'h60, rdata);
    wr(A_ST, 32'h40);
    rd(A_ST);
    chk("status cleared", 32'h20, rdata);
    // receive-only setting must not start a frame
    wr(A_D, 32'h5a);
    repeat (100) @(posedge pclk);
    chk("receive only", 32'd48, {24'h0, edge_cnt});
    // receiver switched off with a byte waiting
    wr(A_B, 32'h18);
    push_tx(1'b0);
    wait_st(7, 1'b1);
    wr(A_B, 32'h08);
    rd(A_ST);
    chk("flushed", 32'h60, rdata);
    chk("input released", 32'h0, {31'h0, rx_owned});
    // a mode other than master spi moves nothing
    wr(A_C, 32'h07);
    wr(A_D, 32'h33);
    repeat (100) @(posedge pclk);
    chk("async mode", 32'd64, {24'h0, edge_cnt});
    summarize();
  end
endmodule : usart_master_spi_control_tb
